// ==== rtl/cfcr_host.sv ====
`include "cfcr_map.svh"

module cfcr_host
    import cfcr_pkg::*;
#(
    parameter int ADDR_W = 5, // axi address width
    parameter logic [1:0] PHASE_MIN = `CFCR_H_PHASE_MIN // earliest phase
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [ADDR_W-1:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [ADDR_W-1:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    output logic irq, // level interrupt
    cfcr_if.host link // register link
);

    // the map needs four words decoded from five address bits
    if (ADDR_W < 5) begin : g_addr_chk
        $error("cfcr_host: ADDR_W must be at least 5");
    end

    cfcr_host_t st_ff; // registered state
    cfcr_host_t nxt_st; // next state
    logic wr_go; // write address and data taken together
    logic rd_go; // read address taken

    // both write channels are taken in one edge, one write at a time
    assign wr_go = awvalid && wvalid && !st_ff.bvalid;
    assign rd_go = arvalid && !st_ff.rvalid;

    // sequencer, axi slave and interrupt bits
    always_comb begin
        logic [1:0] ev;
        logic [7:0] a;
        logic [7:0] d;
        ev = 2'b00;
        a = 8'h00;
        d = 8'h00;
        nxt_st = st_ff;
        nxt_st.wr = 1'b0;
        nxt_st.rd = 1'b0;
        if (st_ff.bvalid && bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (st_ff.rvalid && rready) begin
            nxt_st.rvalid = 1'b0;
        end

        // register writes; a busy command word is ignored
        if (wr_go) begin
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = 2'b00;
            case (ADDR_W'(awaddr))
                ADDR_W'(`CFCR_H_CMD): begin
                    if (wstrb[2:0] != 3'b111) begin
                        nxt_st.bresp = 2'b10; // partial command refused
                    end else if (st_ff.st == hs_idle) begin
                        a = wdata[15:8];
                        d = wdata[7:0];
                        if (!wdata[`CFCR_H_CMD_WRITE]) begin
                            nxt_st.rd = 1'b1;
                            nxt_st.addr = a;
                            nxt_st.st = hs_wait;
                        end else if (a == `CFCR_A_MISC) begin
                            // fetch first so the trim is written back
                            nxt_st.rd = 1'b1;
                            nxt_st.addr = a;
                            nxt_st.wdata = d;
                            nxt_st.st = hs_merge;
                        end else begin
                            if (a == `CFCR_A_BAND) begin
                                d[`CFCR_B_BAND_KEEP] = 1'b1;
                            end
                            if (a == `CFCR_A_TURN && d[1:0] < PHASE_MIN) begin
                                d[1:0] = PHASE_MIN;
                            end
                            nxt_st.wr = 1'b1;
                            nxt_st.addr = a;
                            nxt_st.wdata = d;
                            ev[0] = 1'b1;
                        end
                    end
                end
                ADDR_W'(`CFCR_H_IRQ_STAT): begin
                    if (wstrb[0]) begin
                        nxt_st.irq_stat = st_ff.irq_stat & ~wdata[1:0];
                    end
                end
                ADDR_W'(`CFCR_H_IRQ_MASK): begin
                    if (wstrb[0]) begin
                        nxt_st.irq_mask = wdata[1:0];
                    end
                end
                ADDR_W'(`CFCR_H_STAT): ; // read-only, write has no effect
                default: nxt_st.bresp = 2'b10;
            endcase
        end

        // link answers
        case (st_ff.st)
            hs_merge: begin
                if (link.rvalid) begin
                    nxt_st.wdata = {st_ff.wdata[7:3], link.rdata[2:0]};
                    nxt_st.wr = 1'b1;
                    nxt_st.st = hs_idle;
                    ev[0] = 1'b1;
                end
            end
            hs_wait: begin
                if (link.rvalid) begin
                    nxt_st.rback = link.rdata;
                    nxt_st.st = hs_idle;
                    ev[0] = 1'b1;
                end
            end
            hs_idle: ; // a command may just have left idle
            default: nxt_st.st = hs_idle;
        endcase

        // register reads
        if (rd_go) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = 2'b00;
            case (ADDR_W'(araddr))
                ADDR_W'(`CFCR_H_CMD): begin
                    nxt_st.rdata = {16'h0000, st_ff.addr, st_ff.wdata};
                end
                ADDR_W'(`CFCR_H_STAT): begin
                    nxt_st.rdata = {15'h0000, link.tx_afull, st_ff.rback,
                        7'h00, st_ff.st != hs_idle};
                end
                ADDR_W'(`CFCR_H_IRQ_STAT): begin
                    nxt_st.rdata = {30'h0, st_ff.irq_stat};
                end
                ADDR_W'(`CFCR_H_IRQ_MASK): begin
                    nxt_st.rdata = {30'h0, st_ff.irq_mask};
                end
                default: begin
                    nxt_st.rdata = 32'h0;
                    nxt_st.rresp = 2'b10;
                end
            endcase
        end

        // events set after the clear, so a set in the clear cycle wins
        nxt_st.afull_d = link.tx_afull;
        ev[1] = link.tx_afull && !st_ff.afull_d; // almost-full rise
        nxt_st.irq_stat = nxt_st.irq_stat | ev;
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs
    assign awready = wr_go;
    assign wready = wr_go;
    assign arready = rd_go;
    assign bvalid = st_ff.bvalid;
    assign bresp = st_ff.bresp;
    assign rvalid = st_ff.rvalid;
    assign rresp = st_ff.rresp;
    assign rdata = st_ff.rdata;
    assign irq = |(st_ff.irq_stat & st_ff.irq_mask);
    assign link.addr = st_ff.addr;
    assign link.wdata = st_ff.wdata;
    assign link.wr = st_ff.wr;
    assign link.rd = st_ff.rd;

endmodule

// ==== include/cfcr_map.svh ====
`ifndef CFCR_MAP_SVH
`define CFCR_MAP_SVH

// device register offsets on the link
`define CFCR_A_OFS_LOW 8'h73
`define CFCR_A_OFS_HIGH 8'h74
`define CFCR_A_BAND 8'h75
`define CFCR_A_NOM_HIGH 8'h76
`define CFCR_A_NOM_LOW 8'h77
`define CFCR_A_MISC 8'h78
`define CFCR_A_HOP_CH 8'h79
`define CFCR_A_HOP_STEP 8'h7a
`define CFCR_A_TURN 8'h7b
`define CFCR_A_TXCTL 8'h7c

// device reset values
`define CFCR_R_OFS_LOW 8'h00
`define CFCR_R_OFS_HIGH 8'h00
`define CFCR_R_BAND 8'h75
`define CFCR_R_NOM_HIGH 8'hbb
`define CFCR_R_NOM_LOW 8'h80
`define CFCR_R_MISC 8'h00
`define CFCR_R_HOP_CH 8'h00
`define CFCR_R_HOP_STEP 8'h00
`define CFCR_R_TURN 8'h7b
`define CFCR_R_TXCTL 8'h37

// field positions
`define CFCR_B_BAND_KEEP 5
`define CFCR_B_SIDE_BAND 6
`define CFCR_B_ALT_AMP 3
`define CFCR_B_LEN_CRC 7
`define CFCR_B_TURN_EN 2

// carrier arithmetic, in half hertz
`define CFCR_BAND_BASE 24
`define CFCR_BAND_HALF_HZ 40000000
`define CFCR_OFFSET_HALF_HZ 625
`define CFCR_HOP_HALF_HZ 20000
`define CFCR_CRC_BYTES 2

// controller registers on the axi4-lite side (byte addresses)
`define CFCR_H_CMD 5'h00
`define CFCR_H_STAT 5'h04
`define CFCR_H_IRQ_STAT 5'h08
`define CFCR_H_IRQ_MASK 5'h0c
`define CFCR_H_CMD_WRITE 16
`define CFCR_H_PHASE_MIN 2'h1

`endif

// ==== include/cfcr_pkg.sv ====
package cfcr_pkg;

    // controller sequencing states
    typedef enum logic [1:0] {hs_idle, hs_merge, hs_wait} cfcr_hstate_t;

    // whole state of the device end
    typedef struct packed {
        logic [7:0] ofs_low; // written offset, low byte
        logic [7:0] ofs_high; // written offset, top two bits
        logic [7:0] band;     // band select byte
        logic [7:0] nom_high; // nominal carrier word, high
        logic [7:0] nom_low; // nominal carrier word, low
        logic [7:0] misc;     // miscellaneous settings
        logic [7:0] hop_ch;   // hop channel
        logic [7:0] hop_step; // hop step, 10 khz units
        logic [7:0] turn;     // turn-around and length mode
        logic [7:0] txctl;    // tx almost-full threshold
        logic [9:0] afc;      // latest afc correction
        logic [7:0] rdata;    // read answer
        logic rvalid;         // read answer strobe
        logic afull;          // tx almost full
        logic [35:0] carrier; // carrier in half hertz
        logic shift;          // turn-around shift pulse
        logic shift_done;     // shift already given this byte
        logic [7:0] payload;  // payload byte count
    } cfcr_dev_t;

    // whole state of the controller end
    typedef struct packed {
        cfcr_hstate_t st;  // sequencer state
        logic [7:0] addr;  // link address
        logic [7:0] wdata; // link write data
        logic wr;          // link write strobe
        logic rd;          // link read strobe
        logic [7:0] rback; // last read byte
        logic [1:0] irq_stat; // sticky events
        logic [1:0] irq_mask; // event mask
        logic afull_d;     // previous almost-full
        logic bvalid;      // axi write response
        logic [1:0] bresp;
        logic rvalid;      // axi read response
        logic [1:0] rresp;
        logic [31:0] rdata;
    } cfcr_host_t;

endpackage

// ==== include/cfcr_if.sv ====
// register link between controller and transceiver register bank
interface cfcr_if;
    logic [7:0] addr;  // register offset
    logic [7:0] wdata; // write byte
    logic wr;          // one-cycle write strobe
    logic rd;          // one-cycle read strobe
    logic [7:0] rdata; // read byte
    logic rvalid;      // read answer strobe
    logic tx_afull;    // tx almost-full level
    modport dev (input addr, wdata, wr, rd,
                 output rdata, rvalid, tx_afull);
    modport host (output addr, wdata, wr, rd,
                  input rdata, rvalid, tx_afull);
endinterface

// ==== rtl/cfcr_device.sv ====
// Contract
// - offset is ten-bit two's complement, split bytes
// - one offset step moves carrier 312.5 Hz
// - offset reads return latest afc correction
// - band index steps carrier 20 MHz per count
// - host always writes one to band bit 5
// - carrier equals band, word, offset, hop formula
// - hop channel times step adds displacement
// - hop step counts in 10 kHz units
// - misc bit 3 selects alternate amp sequence
// - host leaves oscillator trim field unchanged
// - length bit 7 makes length count crc
// - host enables crc separately in crc mode; the host has no crc enable logic
// - turn-around bit 2 shifts frequency last byte
// - phase field picks shift bit position
// - host avoids too early turn-around phase
// - six-bit tx almost-full threshold is held
`include "cfcr_map.svh"

module cfcr_device
    import cfcr_pkg::*;
#(
    parameter int FILL_W = 7 // tx buffer fill count width
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    cfcr_if.dev link, // register link

    // modem and afc side
    input wire logic afc_valid, // new afc result strobe
    input wire logic [9:0] afc_offset, // afc result, two's complement
    input wire logic [FILL_W-1:0] tx_fill, // tx buffer fill level
    input wire logic [7:0] pkt_len, // programmed packet length
    input wire logic last_byte, // modem is on the last byte
    input wire logic [2:0] bit_index, // bit being sent in byte

    // decoded settings for the radio
    output logic [35:0] carrier_half_hz, // carrier, half hertz
    output logic [4:0] band_index, // selected band
    output logic side_band, // side band select
    output logic alternate_amp_sequence, // amp sequence choice
    output logic [2:0] rcosc_trim, // oscillator trim
    output logic len_includes_crc, // length counts crc
    output logic [7:0] payload_len, // payload bytes in length
    output logic turnaround_shift, // one-cycle shift pulse
    output logic tx_almost_full // tx almost-full level
);

    // the threshold is six bits wide, the counter must hold it
    // wider counts are fine, the threshold is padded
    if (FILL_W < 6) begin : g_fill_chk
        $error("cfcr_device: FILL_W must be at least 6");
    end

    cfcr_dev_t st_ff; // registered state
    cfcr_dev_t nxt_st; // next state

    // next-state logic: link access, afc capture, derived values
    always_comb begin
        logic [9:0] ofs_wr;
        logic [35:0] band_part;
        logic signed [35:0] off_part;
        logic [35:0] hop_part;
        logic [5:0] thr;

        // defaults, so no path leaves a latch
        ofs_wr = 10'h000;
        band_part = 36'h0;
        off_part = 36'sh0;
        hop_part = 36'h0;
        thr = 6'h00;
        // hold by default; pulses drop unless raised
        nxt_st = st_ff;
        nxt_st.rvalid = 1'b0;
        nxt_st.shift = 1'b0;

        // host writes; reserved read-only bits stay zero
        if (link.wr) begin
            case (link.addr)
                `CFCR_A_OFS_LOW: nxt_st.ofs_low = link.wdata;
                // only the sign and bit 8 live here
                `CFCR_A_OFS_HIGH: begin
                    nxt_st.ofs_high = {6'h00, link.wdata[1:0]};
                end
                // bit 7 is read-only
                `CFCR_A_BAND: nxt_st.band = {1'b0, link.wdata[6:0]};
                `CFCR_A_NOM_HIGH: nxt_st.nom_high = link.wdata;
                `CFCR_A_NOM_LOW: nxt_st.nom_low = link.wdata;
                // trim bits arrive merged by the host
                `CFCR_A_MISC: nxt_st.misc = link.wdata;
                `CFCR_A_HOP_CH: nxt_st.hop_ch = link.wdata;
                `CFCR_A_HOP_STEP: nxt_st.hop_step = link.wdata;
                `CFCR_A_TURN: nxt_st.turn = link.wdata;
                `CFCR_A_TXCTL: nxt_st.txctl = link.wdata;
                default: ; // other offsets are not in this bank
            endcase
        end

        // host reads answer on the next edge; unmapped reads zero
        if (link.rd) begin
            nxt_st.rvalid = 1'b1;
            case (link.addr)
                // reads show the correction, not the write
                `CFCR_A_OFS_LOW: nxt_st.rdata = st_ff.afc[7:0];
                `CFCR_A_OFS_HIGH: begin
                    nxt_st.rdata = {6'h00, st_ff.afc[9:8]};
                end
                `CFCR_A_BAND: nxt_st.rdata = st_ff.band;
                `CFCR_A_NOM_HIGH: nxt_st.rdata = st_ff.nom_high;
                `CFCR_A_NOM_LOW: nxt_st.rdata = st_ff.nom_low;
                `CFCR_A_MISC: nxt_st.rdata = st_ff.misc;
                `CFCR_A_HOP_CH: nxt_st.rdata = st_ff.hop_ch;
                `CFCR_A_HOP_STEP: nxt_st.rdata = st_ff.hop_step;
                `CFCR_A_TURN: nxt_st.rdata = st_ff.turn;
                `CFCR_A_TXCTL: nxt_st.rdata = st_ff.txctl;
                // unmapped offsets answer zero
                default: nxt_st.rdata = 8'h00;
            endcase
        end

        // the afc result replaces what software reads back
        if (afc_valid) begin
            // a host offset write leaves it alone
            nxt_st.afc = afc_offset;
        end

        // carrier in half hertz keeps the 312.5 hz step exact
        ofs_wr = {st_ff.ofs_high[1:0], st_ff.ofs_low};
        // each band count is a 20 mhz step
        band_part = 36'(st_ff.band[4:0] + 6'(`CFCR_BAND_BASE))
            * 36'(`CFCR_BAND_HALF_HZ);
        // word unsigned, offset signed
        off_part = (36'(signed'({2'b00, st_ff.nom_high, st_ff.nom_low}))
            + 36'(signed'(ofs_wr))) * 36'sd625;
        // channel times step, step in 10 khz
        hop_part = 36'(st_ff.hop_ch) * 36'(st_ff.hop_step)
            * 36'(`CFCR_HOP_HALF_HZ);
        nxt_st.carrier = band_part + 36'(off_part) + hop_part;

        // level follows the fill count against the threshold
        // a new threshold acts from the next edge
        thr = st_ff.txctl[5:0];
        nxt_st.afull = (tx_fill >= FILL_W'(thr));

        // length mode: crc bytes are removed to get the payload
        if (st_ff.turn[`CFCR_B_LEN_CRC]) begin
            // guard lengths below the crc size
            if (pkt_len >= 8'(`CFCR_CRC_BYTES)) begin
                nxt_st.payload = pkt_len - 8'(`CFCR_CRC_BYTES);
            end else begin
                nxt_st.payload = 8'h00; // too short to hold crc
            end
        end else begin
            nxt_st.payload = pkt_len;
        end

        // one shift per last byte, at bit 4 plus the phase value
        // shift_done keeps it to one pulse per byte
        if (!last_byte) begin
            nxt_st.shift_done = 1'b0;
        end else if (st_ff.turn[`CFCR_B_TURN_EN] && !st_ff.shift_done
                     && bit_index == {1'b1, st_ff.turn[1:0]}) begin
            nxt_st.shift = 1'b1;
            nxt_st.shift_done = 1'b1;
        end
    end

    // state register with documented reset bytes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // afc, pulses and derived values start at zero
            st_ff <= '0;
            st_ff.ofs_low <= `CFCR_R_OFS_LOW;
            st_ff.ofs_high <= `CFCR_R_OFS_HIGH;
            st_ff.band <= `CFCR_R_BAND;
            st_ff.nom_high <= `CFCR_R_NOM_HIGH;
            st_ff.nom_low <= `CFCR_R_NOM_LOW;
            st_ff.misc <= `CFCR_R_MISC;
            st_ff.hop_ch <= `CFCR_R_HOP_CH;
            st_ff.hop_step <= `CFCR_R_HOP_STEP;
            st_ff.turn <= `CFCR_R_TURN;
            st_ff.txctl <= `CFCR_R_TXCTL;
        end else begin
            // no enable: every edge loads
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state
    assign link.rdata = st_ff.rdata;
    assign link.rvalid = st_ff.rvalid;
    assign link.tx_afull = st_ff.afull;

    // settings as the radio sees them
    assign carrier_half_hz = st_ff.carrier;
    assign band_index = st_ff.band[4:0];
    assign side_band = st_ff.band[`CFCR_B_SIDE_BAND];
    assign alternate_amp_sequence = st_ff.misc[`CFCR_B_ALT_AMP];
    assign rcosc_trim = st_ff.misc[2:0];

    // length and turn-around decode
    assign len_includes_crc = st_ff.turn[`CFCR_B_LEN_CRC];
    assign payload_len = st_ff.payload;
    assign turnaround_shift = st_ff.shift;
    assign tx_almost_full = st_ff.afull;

endmodule

// ==== verif/cfcr_monitor.sv ====
// watches the register link between the two ends
module cfcr_monitor #(
    parameter logic [1:0] PHASE_MIN = 2'h1 // earliest allowed phase
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [7:0] addr, // register offset
    input wire logic [7:0] wdata, // write byte
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    input wire logic [7:0] rdata, // read byte
    input wire logic rvalid, // read answer strobe
    input wire logic tx_afull // tx almost-full level
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [2:0] trim_ff; // trim bits of the last read answer
    // keep the readback so a later write can be compared with it
    always_ff @(posedge aclk) begin
        if (rvalid) begin
            trim_ff <= rdata[2:0];
        end
    end
    // a read is one strobe then one answer cycle
    sequence link_read;
        rd ##1 (rvalid && !rd);
    endsequence
    a_read_answer_lag: assert property (rd |-> link_read)
        else $error("read answer did not follow one cycle later");
    a_answer_needs_read: assert property (rvalid |-> $past(rd))
        else $error("read answer without a read");
    a_offset_high_reserved: assert property (
        rvalid && $past(addr) == 8'h74 |-> rdata[7:2] == 6'h00)
        else $error("offset high byte reserved bits not zero");
    a_band_top_clear: assert property (
        rvalid && $past(addr) == 8'h75 |-> !rdata[7])
        else $error("band register bit 7 read back set");
    a_band_keep_bit: assert property (
        wr && addr == 8'h75 |-> wdata[5])
        else $error("band write without bit 5 set");
    a_phase_not_early: assert property (
        wr && addr == 8'h7b |-> wdata[1:0] >= PHASE_MIN)
        else $error("turn-around phase written too early");
    a_trim_readback: assert property (
        wr && addr == 8'h78 |-> $past(rd, 2) && $past(addr, 2) == 8'h78
        && wdata[2:0] == trim_ff)
        else $error("trim field changed by a settings write");
    a_strobe_exclusive: assert property (!(wr && rd))
        else $error("read and write strobes together");
    cover property (tx_afull);
endmodule

// ==== verif/testbench.sv ====
`include "cfcr_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, afc_valid = 0, last_byte = 0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic side_band, alt_seq, len_crc, shift, afull;
    logic [4:0] awaddr = 0, araddr = 0, band_index;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp, resp;
    logic [9:0] afc_offset = 0;
    logic [6:0] tx_fill = 0;
    logic [7:0] pkt_len = 0, payload_len, b;
    logic [2:0] bit_index = 0, trim;
    logic [35:0] carrier;
    logic [31:0] d;
    int fails = 0, check_count = 0, cycles = 0;
    cfcr_if lnk();
    cfcr_device i_cfcr_device (.aclk(aclk), .aresetn(aresetn), .link(lnk),
        .afc_valid(afc_valid), .afc_offset(afc_offset), .tx_fill(tx_fill),
        .pkt_len(pkt_len), .last_byte(last_byte), .bit_index(bit_index),
        .carrier_half_hz(carrier), .band_index(band_index),
        .side_band(side_band), .alternate_amp_sequence(alt_seq),
        .rcosc_trim(trim), .len_includes_crc(len_crc),
        .payload_len(payload_len), .turnaround_shift(shift),
        .tx_almost_full(afull));
    cfcr_host i_cfcr_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .irq(irq), .link(lnk));
    cfcr_monitor i_cfcr_monitor (.aclk(aclk), .aresetn(aresetn),
        .addr(lnk.addr), .wdata(lnk.wdata), .wr(lnk.wr), .rd(lnk.rd),
        .rdata(lnk.rdata), .rvalid(lnk.rvalid), .tx_afull(lnk.tx_afull));
    // clock and hang guard
    initial begin
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (fails == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // write: address and data offered together, each released when taken
    task automatic axi_write(input logic [4:0] a, input logic [31:0] v);
        logic aw_go, w_go;
        @(posedge aclk);
        awaddr <= a; wdata <= v; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1;
        aw_go = 1; w_go = 1;
        while (aw_go || w_go) begin
            @(posedge aclk);
            if (aw_go && awready === 1) begin awvalid <= 0; aw_go = 0; end
            if (w_go && wready === 1) begin wvalid <= 0; w_go = 0; end
        end
        bready <= 1;
        do @(posedge aclk); while (bvalid !== 1);
        resp = bresp;
        bready <= 0;
    endtask
    task automatic axi_read(input logic [4:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1;
        do @(posedge aclk); while (arready !== 1);
        arvalid <= 0; rready <= 1;
        do @(posedge aclk); while (rvalid !== 1);
        d = rdata; resp = rresp;
        rready <= 0;
    endtask
    // device register access through the command register
    task automatic wait_idle();
        do axi_read(`CFCR_H_STAT); while (d[0] !== 0);
    endtask
    task automatic dev_write(input logic [7:0] off, input logic [7:0] v);
        axi_write(`CFCR_H_CMD, {15'h0, 1'b1, off, v});
        wait_idle();
    endtask
    task automatic dev_read(input logic [7:0] off);
        axi_write(`CFCR_H_CMD, {16'h0, off, 8'h00});
        wait_idle();
        b = d[15:8];
    endtask
    function automatic logic [35:0] exp_carrier(int bi, int nom, int ofs,
        int ch, int st);
        longint v;
        v = longint'(bi + 24) * 40000000 + longint'(nom + ofs) * 625;
        return 36'(v + longint'(ch * st) * 20000);
    endfunction
    task automatic t_reset_values();
        logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h75, 8'hbb, 8'h80,
            8'h00, 8'h00, 8'h00, 8'h7b, 8'h37};
        repeat (2) @(posedge aclk);
        check(carrier, exp_carrier(21, 16'hbb80, 0, 0, 0));
        for (int i = 0; i < 10; i++) begin
            dev_read(8'h73 + 8'(i));
            check(b, rv[i]);
        end
    endtask
    task automatic t_carrier();
        dev_write(8'h75, 8'h56);
        dev_write(8'h76, 8'hc0);
        dev_write(8'h77, 8'h00);
        dev_write(8'h74, 8'h03);
        dev_write(8'h73, 8'hf0);
        dev_write(8'h79, 8'h03);
        dev_write(8'h7a, 8'h05);
        check(band_index, 5'h16);
        check(side_band, 1'b1);
        dev_read(8'h75);
        check(b, 8'h76);
        check(carrier, exp_carrier(22, 16'hc000, -16, 3, 5));
    endtask
    task automatic t_afc();
        @(posedge aclk);
        afc_offset <= 10'h2a5; afc_valid <= 1;
        @(posedge aclk);
        afc_valid <= 0;
        dev_read(8'h73);
        check(b, 8'ha5);
        dev_read(8'h74);
        check(b, 8'h02);
        check(carrier, exp_carrier(22, 16'hc000, -16, 3, 5));
    endtask
    task automatic t_misc_len();
        dev_write(8'h78, 8'h0f);
        check({alt_seq, trim}, 4'h8);
        dev_read(8'h78);
        check(b, 8'h08);
        pkt_len <= 8'h09;
        dev_write(8'h7b, 8'h80);
        check({len_crc, payload_len}, 9'h107);
        dev_write(8'h7b, 8'h01);
        check({len_crc, payload_len}, 9'h009);
    endtask
    task automatic t_turnaround();
        int n, at, want;
        for (int p = 0; p < 4; p++) begin
            dev_write(8'h7b, {5'h0, 1'b1, 2'(p)});
            want = 4 + ((p < 1) ? 1 : p) + 2;
            n = 0; at = 0;
            last_byte <= 1;
            bit_index <= 3'h0;
            for (int i = 0; i < 11; i++) begin
                @(posedge aclk);
                if (shift === 1) begin n++; at = i; end
                bit_index <= (i < 8) ? 3'(i) : 3'h7;
            end
            last_byte <= 0;
            check(n, 1);
            check(at, want);
        end
    endtask
    task automatic t_afull_irq();
        axi_write(`CFCR_H_IRQ_MASK, 32'h0);
        axi_write(`CFCR_H_IRQ_STAT, 32'h3);
        dev_write(8'h7c, 8'h10);
        tx_fill <= 7'h0f;
        axi_read(`CFCR_H_STAT);
        check(d[16], 1'b0);
        check(irq, 1'b0);
        tx_fill <= 7'h10;
        axi_read(`CFCR_H_STAT);
        check({afull, d[16]}, 2'b11);
        axi_read(`CFCR_H_IRQ_STAT);
        check(d[1], 1'b1);
        axi_write(`CFCR_H_IRQ_MASK, 32'h2);
        check(irq, 1'b1);
        axi_write(`CFCR_H_IRQ_STAT, 32'h3);
        check(irq, 1'b0);
        tx_fill <= 7'h0f;
        axi_read(`CFCR_H_STAT);
        check({afull, d[16]}, 2'b00);
        axi_read(5'h14);
        check(resp, 2'b10);
        axi_write(5'h10, 32'h0);
        check(resp, 2'b10);
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        t_reset_values();
        t_carrier();
        t_afc();
        t_misc_len();
        t_turnaround();
        t_afull_irq();
        complete_run();
    end
endmodule
